// file: common/atoc_defines.svh
/*
 * Constants of the thread-ordering and error-trapping controller.
 * Assumes it is included by bare name after the package is compiled.
 */
`ifndef ATOC_DEFINES_SVH
`define ATOC_DEFINES_SVH
`define ATOC_NUM_UP       2
`define ATOC_NUM_DN       2
`define ATOC_NUM_RANGES   2
`define ATOC_S0_BASE      32'h0000_0000
`define ATOC_S0_MASK      32'hC000_0000
`define ATOC_S1_BASE      32'h4000_0000
`define ATOC_S1_MASK      32'hFFFF_0000
`define ATOC_WR_EN        2'h3
`define ATOC_RD_EN        2'h3
`define ATOC_SECURE       2'h0
`define ATOC_A3_SLOT      1'h0
`define ATOC_LITE_SLOT    1'h1
`define ATOC_A3_MAXLEN    8'h0F
`define ATOC_A3_STEP      8'h10
`define ATOC_LITE_MAXSIZE 3'h2
`define ATOC_CNT_MAX      4'hF
`define ATOC_BASE_ID0     2'h0
`define ATOC_BASE_ID1     2'h1
`define ATOC_RESP_DECERR  2'h3
`endif

// file: common/atoc_pkg.sv
/*
 * Types of the thread-ordering and error-trapping controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package atoc_pkg;
	// Local error responder phases
	typedef enum logic [1:0] {
		ERR_IDLE,
		ERR_DRAIN,
		ERR_BEATS
	} atoc_err_e;
	// Thread table entry index {dir, up, thread}
	typedef logic [3:0] atoc_idx_t;
endpackage : atoc_pkg

// file: hw/atoc_xbar_ctrl.sv
/*
 * Transaction control of a two-up, two-down crossbar: thread ordering,
 * error trapping with a local responder, a lite-slot single-threader
 * on slot 1 and a long-burst splitter on slot 0.
 * Assumes masters hold cmd_valid and fields until cmd_ack, downstream
 * holds rsp fields until rsp_ready, all on ref_clk.
 */
// Overview of operation
// R1: each thread targets one downstream slot only
// R2: hold until same-direction earlier responses finish
// R3: downstream slots take many sources' commands
// R4: ordering active beyond one-to-one pass-through
// R5: unmapped address answered DECERR, not forwarded
// R6: range check off disables decode trap
// R7: range check defaults on for multi-slot maps
// R8: lite slot bursts or wide sizes trapped
// R9: lite checks off when range check off
// R10: non-secure access to secure slot trapped
// R11: secure slots need range check enabled
// R12: unmapped response ID never gets ready
// R13: write data follows write address order
// R14: masters keep narrow-burst and cache rules
// R15: lite slot one transaction, write/read round-robin
// R16: lite shares one address onto both buses
// R17: lite strips ID, returns it on response
// R18: masters send single small lite beats
// R19: burst splitter sits at the old-protocol slot
// R20: split bursts over sixteen beats, keep size
// R21: splitting command allows one outstanding per direction
// R22: single slot range check chooses pass-through
// R23: per-upstream prefix prepended to each ID
// R24: security violation answered locally, write data drained
// R25: split pieces give one reply, last once
// R26: read error returns len plus one beats, last flagged
`include "atoc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module atoc_xbar_ctrl
	import atoc_pkg::*;
#(
	parameter bit RANGE_CHECK = (`ATOC_NUM_DN > 1) ||
		(`ATOC_NUM_RANGES > 1) // R7
) (
	input  wire logic                   ref_clk,
	input  wire logic                   srst,
	input  wire logic [1:0][1:0]        cmd_valid,
	input  wire logic [1:0][1:0][1:0]   cmd_id,
	input  wire logic [1:0][1:0][31:0]  cmd_addr,
	input  wire logic [1:0][1:0][7:0]   cmd_len,
	input  wire logic [1:0][1:0][2:0]   cmd_size,
	input  wire logic [1:0][1:0][2:0]   cmd_prot,
	input  wire logic [1:0]             wd_last,
	input  wire logic                   dn_ready,
	input  wire logic                   rsp_valid,
	input  wire logic                   rsp_dir,
	input  wire logic                   rsp_slot,
	input  wire logic [3:0]             rsp_id,
	input  wire logic [1:0]             rsp_resp,
	input  wire logic                   rsp_last,
	output logic      [1:0][1:0]        cmd_ack,
	output logic                        dn_valid,
	output logic                        dn_dir,
	output logic                        dn_slot,
	output logic      [3:0]             dn_id,
	output logic      [31:0]            dn_addr,
	output logic      [7:0]             dn_len,
	output logic      [2:0]             dn_size,
	output logic      [31:0]            lite_awaddr,
	output logic      [31:0]            lite_araddr,
	output logic                        rsp_ready,
	output logic                        up_valid,
	output logic                        up_dir,
	output logic                        up_port,
	output logic      [1:0]             up_id,
	output logic      [1:0]             up_resp,
	output logic                        up_last
);
	// Ordering is needed unless one up feeds one down
	localparam bit SSPI_EN = !(`ATOC_NUM_UP == 1 && `ATOC_NUM_DN == 1); // R4
	localparam logic [1:0] SEC_MAP = `ATOC_SECURE; // Secure slot flags

	// Per-slot address hits, gated by direction eligibility
	function automatic logic [1:0] hits(logic d, logic [31:0] a);
		logic [1:0] h;
		h[0] = (a & `ATOC_S0_MASK) == `ATOC_S0_BASE;
		h[1] = (a & `ATOC_S1_MASK) == `ATOC_S1_BASE;
		return h & (d ? `ATOC_RD_EN : `ATOC_WR_EN);
	endfunction : hits

	// Thread table index
	function automatic atoc_idx_t tix(logic d, logic u, logic [1:0] t);
		return {d, u, t};
	endfunction : tix

	// Fixed master prefix per upstream slot
	function automatic logic [1:0] base_id(logic u);
		return u ? `ATOC_BASE_ID1 : `ATOC_BASE_ID0;
	endfunction : base_id

	// Thread table: outstanding count and target slot
	logic [3:0] cnt_r   [16];
	logic [3:0] cnt_nxt [16];
	logic       tgt_r   [16];
	logic       tgt_nxt [16];
	logic       tab_inc, tab_dec;      // Table update strobes
	atoc_idx_t  tab_ie, tab_de;        // Table update entries

	// Control state
	logic [1:0][1:0] ack_r, ack_nxt;   // Command taken pulses
	logic        dnv_r, dnv_nxt;       // Issue register full
	logic        dnd_r, dnd_nxt;       // Issue direction
	logic        dns_r, dns_nxt;       // Issue slot
	logic [3:0]  dni_r, dni_nxt;       // Prefixed ID
	logic [31:0] dna_r, dna_nxt;       // Issue address
	logic [7:0]  dnl_r, dnl_nxt;       // Issue length
	logic [2:0]  dnz_r, dnz_nxt;       // Issue size
	logic        sp_act_r, sp_act_nxt; // Pieces still to issue
	logic [7:0]  sp_left_r, sp_left_nxt;
	logic [1:0]  sp_pend_r, sp_pend_nxt;
	logic [1:0][4:0] sp_cnt_r, sp_cnt_nxt;  // Pieces awaiting reply
	logic [1:0][7:0] a3_cnt_r, a3_cnt_nxt;  // Slot 0 outstanding
	logic        lb_r, lb_nxt;         // Lite slot busy
	logic [3:0]  lid_r, lid_nxt;       // Lite stored ID
	logic [31:0] la_r, la_nxt;         // Lite shared address
	logic [1:0]  rru_r, rru_nxt;       // Up priority per dir
	logic        rrd_r, rrd_nxt;       // Dir priority
	atoc_err_e   es_r, es_nxt;         // Error responder phase
	logic        ed_r, ed_nxt;
	logic        eu_r, eu_nxt;
	logic [1:0]  eid_r, eid_nxt;
	logic [7:0]  ec_r, ec_nxt;         // Beats left minus one
	logic        rr_r, rr_nxt;         // rsp_ready
	logic        uv_r, uv_nxt, ud_r, ud_nxt, up_r, up_nxt;
	logic [1:0]  ui_r, ui_nxt, ur_r, ur_nxt;
	logic        ul_r, ul_nxt;

	// Request evaluation
	logic [1:0][1:0] rq_go, rq_err, rq_slot, rq_split;
	logic        acc_v, acc_d, acc_u, acc_err, acc_slot, acc_busy;
	logic        acc_tgt, acc_fwd, rsp_map;
	atoc_idx_t   acc_e;

	// Decode, trap and block decision for each requester
	always_comb begin : req_eval
		logic [1:0] h;
		logic       s, bad, busy, blk;
		atoc_idx_t  e;
		h = '0;
		s = 1'b0;
		bad = 1'b0;
		busy = 1'b0;
		blk = 1'b0;
		e = '0;
		rq_go = '0;
		rq_err = '0;
		rq_slot = '0;
		rq_split = '0;
		for (int d = 0; d < 2; d++) begin
			for (int u = 0; u < 2; u++) begin
				h = hits(d[0], cmd_addr[d][u]);
				// Lower slot wins; no hit defaults to slot 0 // R22
				s = !h[0] && h[1];
				// Decode and lite shape traps need range check // R6
				bad = RANGE_CHECK && (h == 2'h0); // R5
				if (RANGE_CHECK && s == `ATOC_LITE_SLOT && // R9
					(cmd_len[d][u] != 8'h00 ||
					cmd_size[d][u] > `ATOC_LITE_MAXSIZE))
					bad = 1'b1; // R8
				if (cmd_prot[d][u][1] && SEC_MAP[s])
					bad = 1'b1; // R10
				e = tix(d[0], u[0], cmd_id[d][u]);
				busy = cnt_r[e] != 4'h0;
				// Thread busy elsewhere, or trap behind outstanding
				blk = SSPI_EN && busy && (bad || tgt_r[e] != s); // R1
				if (cnt_r[e] == `ATOC_CNT_MAX)
					blk = 1'b1;
				if (!bad && s == `ATOC_LITE_SLOT && lb_r)
					blk = 1'b1; // R15
				rq_split[d][u] = !bad && s == `ATOC_A3_SLOT &&
					cmd_len[d][u] > `ATOC_A3_MAXLEN; // R19
				if (!bad && s == `ATOC_A3_SLOT && (sp_pend_r[d] ||
					(rq_split[d][u] && a3_cnt_r[d] != 8'h00)))
					blk = 1'b1; // R21
				rq_slot[d][u] = s;
				rq_err[d][u] = bad;
				rq_go[d][u] = cmd_valid[d][u] && !ack_r[d][u] && !blk;
			end
		end
	end

	// Round-robin choice of one requester
	always_comb begin : acc_sel
		logic [1:0] su;
		su = '0;
		for (int d = 0; d < 2; d++)
			su[d] = rq_go[d][rru_r[d]] ? rru_r[d] : !rru_r[d];
		// Write versus read alternates when both pend // R15
		acc_d = (|rq_go[0] && |rq_go[1]) ? rrd_r : |rq_go[1];
		acc_u = su[acc_d];
		acc_v = (|rq_go) && !dnv_r && !sp_act_r && es_r == ERR_IDLE;
		acc_err = rq_err[acc_d][acc_u];
		acc_slot = rq_slot[acc_d][acc_u];
		acc_e = tix(acc_d, acc_u, cmd_id[acc_d][acc_u]);
		acc_busy = cnt_r[acc_e] != 4'h0;
		acc_tgt = tgt_r[acc_e];
		acc_fwd = acc_v && !acc_err;
		// Slot 1 uses the stored ID; slot 0 must carry a known prefix
		rsp_map = rsp_slot == `ATOC_LITE_SLOT ||
			rsp_id[3:2] == `ATOC_BASE_ID0 ||
			rsp_id[3:2] == `ATOC_BASE_ID1;
	end

	// Next state of issue, split, lite and response logic
	always_comb begin : ctl_nxt
		logic [3:0] rid;
		logic       fin, pend_end, a3i, a3d;
		rid = '0;
		fin = 1'b0;
		pend_end = 1'b0;
		a3i = 1'b0;
		a3d = 1'b0;
		ack_nxt = '0;
		dnv_nxt = dnv_r;
		dnd_nxt = dnd_r;
		dns_nxt = dns_r;
		dni_nxt = dni_r;
		dna_nxt = dna_r;
		dnl_nxt = dnl_r;
		dnz_nxt = dnz_r;
		sp_act_nxt = sp_act_r;
		sp_left_nxt = sp_left_r;
		sp_pend_nxt = sp_pend_r;
		sp_cnt_nxt = sp_cnt_r;
		a3_cnt_nxt = a3_cnt_r;
		lb_nxt = lb_r;
		lid_nxt = lid_r;
		la_nxt = la_r;
		rru_nxt = rru_r;
		rrd_nxt = rrd_r;
		es_nxt = es_r;
		ed_nxt = ed_r;
		eu_nxt = eu_r;
		eid_nxt = eid_r;
		ec_nxt = ec_r;
		rr_nxt = 1'b0;
		uv_nxt = 1'b0;
		ud_nxt = ud_r;
		up_nxt = up_r;
		ui_nxt = ui_r;
		ur_nxt = ur_r;
		ul_nxt = ul_r;
		tab_inc = 1'b0;
		tab_dec = 1'b0;
		tab_ie = acc_e;
		tab_de = '0;
		// Take one command
		if (acc_v) begin
			ack_nxt[acc_d][acc_u] = 1'b1;
			rru_nxt[acc_d] = !acc_u;
			rrd_nxt = !acc_d;
			if (acc_err) begin
				// Answer locally, nothing goes downstream // R24
				es_nxt = acc_d ? ERR_BEATS : ERR_DRAIN;
				ed_nxt = acc_d;
				eu_nxt = acc_u;
				eid_nxt = cmd_id[acc_d][acc_u];
				ec_nxt = cmd_len[acc_d][acc_u];
			end else begin
				// Commands leave in acceptance order // R13
				dnv_nxt = 1'b1;
				dnd_nxt = acc_d;
				dns_nxt = acc_slot;
				dni_nxt = {base_id(acc_u), cmd_id[acc_d][acc_u]}; // R23
				dna_nxt = cmd_addr[acc_d][acc_u];
				dnz_nxt = cmd_size[acc_d][acc_u];
				dnl_nxt = cmd_len[acc_d][acc_u];
				tab_inc = 1'b1; // R3
				if (rq_split[acc_d][acc_u]) begin
					// First piece of sixteen beats // R20
					dnl_nxt = `ATOC_A3_MAXLEN;
					sp_act_nxt = 1'b1;
					sp_left_nxt = cmd_len[acc_d][acc_u] - `ATOC_A3_STEP;
					sp_pend_nxt[acc_d] = 1'b1;
					sp_cnt_nxt[acc_d] = {1'b0, cmd_len[acc_d][acc_u][7:4]}
						+ 5'h01;
				end
				if (acc_slot == `ATOC_A3_SLOT)
					a3i = 1'b1;
				if (acc_slot == `ATOC_LITE_SLOT) begin
					lb_nxt = 1'b1;
					lid_nxt = {base_id(acc_u), cmd_id[acc_d][acc_u]}; // R17
					la_nxt = cmd_addr[acc_d][acc_u]; // R16
				end
			end
		end
		// Issue handshake; next piece keeps the size
		if (dnv_r && dn_ready) begin
			if (sp_act_r) begin
				dna_nxt = dna_r + (32'h0000_0010 << dnz_r); // R20
				if (sp_left_r > `ATOC_A3_MAXLEN) begin
					dnl_nxt = `ATOC_A3_MAXLEN;
					sp_left_nxt = sp_left_r - `ATOC_A3_STEP;
				end else begin
					dnl_nxt = sp_left_r;
					sp_act_nxt = 1'b0;
				end
			end else
				dnv_nxt = 1'b0;
		end
		// Local error responder has the return path first
		if (es_r == ERR_DRAIN) begin
			// Write data swallowed, then one reply // R24
			if (wd_last[eu_r]) begin
				uv_nxt = 1'b1;
				ul_nxt = 1'b1;
				es_nxt = ERR_IDLE;
			end
		end else if (es_r == ERR_BEATS) begin
			// One DECERR beat per requested beat // R26
			uv_nxt = 1'b1;
			ul_nxt = ec_r == 8'h00;
			ec_nxt = ec_r - 8'h01;
			if (ec_r == 8'h00)
				es_nxt = ERR_IDLE;
		end else if (rsp_valid && !rr_r && rsp_map) begin
			// Unmapped slot 0 replies are never taken // R12
			rr_nxt = 1'b1;
			rid = rsp_slot == `ATOC_LITE_SLOT ? lid_r : rsp_id; // R17
			pend_end = rsp_dir ? rsp_last : 1'b1;
			fin = !(rsp_slot == `ATOC_A3_SLOT && sp_pend_r[rsp_dir]) ||
				sp_cnt_r[rsp_dir] == 5'h01;
			// Early write pieces are swallowed // R25
			uv_nxt = rsp_dir || fin;
			ud_nxt = rsp_dir;
			up_nxt = rid[3:2] == `ATOC_BASE_ID1;
			ui_nxt = rid[1:0];
			ur_nxt = rsp_resp;
			ul_nxt = rsp_last && fin; // R25
			if (pend_end && rsp_slot == `ATOC_A3_SLOT &&
				sp_pend_r[rsp_dir]) begin
				sp_cnt_nxt[rsp_dir] = sp_cnt_r[rsp_dir] - 5'h01;
				if (fin)
					sp_pend_nxt[rsp_dir] = 1'b0;
			end
			if (pend_end && fin) begin
				// Completion frees the thread // R2
				tab_dec = 1'b1;
				tab_de = tix(rsp_dir, rid[3:2] == `ATOC_BASE_ID1, rid[1:0]);
				if (rsp_slot == `ATOC_A3_SLOT)
					a3d = 1'b1;
				else
					lb_nxt = 1'b0;
			end
		end
		if (es_r != ERR_IDLE) begin
			ud_nxt = ed_r;
			up_nxt = eu_r;
			ui_nxt = eid_r;
			ur_nxt = `ATOC_RESP_DECERR;
		end
		// Slot 0 outstanding per direction
		if (a3i)
			a3_cnt_nxt[acc_d] = a3_cnt_nxt[acc_d] + 8'h01;
		if (a3d)
			a3_cnt_nxt[rsp_dir] = a3_cnt_nxt[rsp_dir] - 8'h01;
	end

	// Thread table next values
	always_comb begin : tab_next
		cnt_nxt = cnt_r;
		tgt_nxt = tgt_r;
		for (int e = 0; e < 16; e++) begin
			if (tab_inc && tab_ie == e[3:0]) begin
				cnt_nxt[e] = cnt_nxt[e] + 4'h1;
				tgt_nxt[e] = acc_slot; // R1
			end
			if (tab_dec && tab_de == e[3:0])
				cnt_nxt[e] = cnt_nxt[e] - 4'h1;
		end
	end

	// Register all state
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_r <= '{default: 4'h0};
			tgt_r <= '{default: 1'b0};
			{ack_r, dnv_r, dnd_r, dns_r, dni_r, dna_r, dnl_r} <= '0;
			{dnz_r, sp_act_r, sp_left_r, sp_pend_r, sp_cnt_r} <= '0;
			{a3_cnt_r, lb_r, lid_r, la_r, rru_r, rrd_r} <= '0;
			es_r <= ERR_IDLE;
			{ed_r, eu_r, eid_r, ec_r, rr_r, uv_r, ud_r} <= '0;
			{up_r, ui_r, ur_r, ul_r} <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			tgt_r <= tgt_nxt;
			{ack_r, dnv_r, dnd_r, dns_r} <= {ack_nxt, dnv_nxt, dnd_nxt,
				dns_nxt};
			{dni_r, dna_r, dnl_r, dnz_r} <= {dni_nxt, dna_nxt, dnl_nxt,
				dnz_nxt};
			{sp_act_r, sp_left_r, sp_pend_r, sp_cnt_r} <= {sp_act_nxt,
				sp_left_nxt, sp_pend_nxt, sp_cnt_nxt};
			{a3_cnt_r, lb_r, lid_r, la_r} <= {a3_cnt_nxt, lb_nxt, lid_nxt,
				la_nxt};
			{rru_r, rrd_r, ed_r, eu_r} <= {rru_nxt, rrd_nxt, ed_nxt, eu_nxt};
			es_r <= es_nxt;
			{eid_r, ec_r, rr_r, uv_r, ud_r} <= {eid_nxt, ec_nxt, rr_nxt,
				uv_nxt, ud_nxt};
			{up_r, ui_r, ur_r, ul_r} <= {up_nxt, ui_nxt, ur_nxt, ul_nxt};
		end
	end

	// Outputs straight from registers
	assign cmd_ack = ack_r;
	assign {dn_valid, dn_dir, dn_slot, dn_id} = {dnv_r, dnd_r, dns_r, dni_r};
	assign {dn_addr, dn_len, dn_size} = {dna_r, dnl_r, dnz_r};
	assign lite_awaddr = la_r;
	assign lite_araddr = la_r;
	assign rsp_ready = rr_r;
	assign {up_valid, up_dir, up_port, up_id} = {uv_r, ud_r, up_r, ui_r};
	assign {up_resp, up_last} = {ur_r, ul_r};

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_thread_target: assert property ( // R1
		acc_fwd && acc_busy |-> acc_slot == acc_tgt)
		else $error("thread sent to a second slot");
	chk_thread_wait: assert property ( // R2
		acc_v && acc_err |-> !acc_busy)
		else $error("trap overtook outstanding thread");
	chk_err_no_fwd: assert property ( // R5
		acc_v && acc_err && !dnv_r |=> !dnv_r)
		else $error("trapped command forwarded");
	chk_lite_shape: assert property ( // R8
		acc_fwd && acc_slot == `ATOC_LITE_SLOT && RANGE_CHECK |->
		cmd_len[acc_d][acc_u] == 8'h00 &&
		cmd_size[acc_d][acc_u] <= `ATOC_LITE_MAXSIZE)
		else $error("bad lite access forwarded");
	chk_sec_trap: assert property ( // R10
		acc_v && cmd_prot[acc_d][acc_u][1] && SEC_MAP[acc_slot]
		|-> acc_err)
		else $error("non-secure access reached secure slot");
	chk_range_secure: assert property ( // R11
		RANGE_CHECK || `ATOC_SECURE == 2'h0)
		else $error("secure slot without range check");
	chk_unmapped_hold: assert property ( // R12
		rsp_valid && !rsp_map |=> !rr_r)
		else $error("unmapped reply accepted");
	chk_lite_one: assert property ( // R15
		lb_r |-> !(acc_fwd && acc_slot == `ATOC_LITE_SLOT))
		else $error("second lite transaction issued");
	chk_split_len: assert property ( // R20
		dnv_r && dns_r == `ATOC_A3_SLOT |-> dnl_r <= `ATOC_A3_MAXLEN)
		else $error("piece longer than sixteen beats");
	chk_split_single: assert property ( // R21
		acc_fwd && acc_slot == `ATOC_A3_SLOT |-> !sp_pend_r[acc_d])
		else $error("command beside a split one");
	chk_err_last: assert property ( // R26
		es_r == ERR_BEATS && ec_r == 8'h00 |=>
		uv_r && ul_r && ur_r == `ATOC_RESP_DECERR ##1 !uv_r || acc_v)
		else $error("read error burst end wrong");
endmodule : atoc_xbar_ctrl
`default_nettype wire

// file: bench/atoc_slave_model.sv
/*
 * Downstream slave model: takes issued commands, replies in order.
 * Assumes one clock ref_clk, sync srst and the controller's handshakes.
 */
`timescale 1ns/10ps
`default_nettype none
module atoc_slave_model (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       dn_valid,
	input  wire logic       dn_dir,
	input  wire logic       dn_slot,
	input  wire logic [3:0] dn_id,
	input  wire logic [7:0] dn_len,
	input  wire logic       rsp_ready,
	input  wire logic       hold,      // Withhold new replies
	input  wire logic       slow,      // Accept one cycle in four
	input  wire logic       bad_id,    // Offer a reply with unknown prefix
	output var  logic       dn_ready,
	output var  logic       rsp_valid,
	output var  logic       rsp_dir,
	output var  logic       rsp_slot,
	output var  logic [3:0] rsp_id,
	output var  logic [1:0] rsp_resp,
	output var  logic       rsp_last
);
	logic [13:0] pend_q[$];  // Accepted {dir,slot,id,len}
	logic [7:0]  beat_r;     // Beat index of current reply
	logic [1:0]  wait_r;     // Slow-accept phase

	// Quiet lines before reset
	initial begin
		{dn_ready, rsp_valid, rsp_dir, rsp_slot, rsp_last} = 5'h00;
		{rsp_id, rsp_resp, beat_r, wait_r} = 16'h0000;
	end

	// Accept commands, replay them as replies
	always @(posedge ref_clk) begin
		if (srst) begin
			pend_q.delete();
			{dn_ready, rsp_valid, rsp_dir, rsp_slot, rsp_last} <= 5'h00;
			{rsp_id, rsp_resp, beat_r, wait_r} <= 16'h0000;
		end else begin
			wait_r <= wait_r + 2'h1;
			dn_ready <= dn_valid && !dn_ready && (!slow || wait_r == 2'h3);
			if (dn_valid && dn_ready)
				pend_q.push_back({dn_dir, dn_slot, dn_id, dn_len});
			if (rsp_valid && rsp_ready) begin
				if (!rsp_dir || rsp_last) begin
					// Reply done; released lines show junk
					rsp_valid <= 1'b0;
					rsp_id    <= ~rsp_id;
					rsp_resp  <= ~rsp_resp;
					void'(pend_q.pop_front());
				end else begin
					// Next read beat
					beat_r   <= beat_r + 8'h01;
					rsp_last <= (beat_r + 8'h01 == pend_q[0][7:0]);
				end
			end else if (!rsp_valid && bad_id) begin
				// Write reply with prefix 2 on slot 0
				rsp_valid <= 1'b1;
				{rsp_dir, rsp_slot, rsp_id, rsp_resp} <= 8'h28;
				rsp_last  <= 1'b1;
			end else if (!rsp_valid && !hold && pend_q.size() > 0) begin
				// Oldest reply; lite slave gives a junk ID
				rsp_valid <= 1'b1;
				{rsp_dir, rsp_slot, rsp_id} <= pend_q[0][13:8] |
					{2'h0, {4{pend_q[0][12]}}};
				rsp_resp  <= 2'h0;
				beat_r    <= 8'h00;
				rsp_last  <= (pend_q[0][7:0] == 8'h00);
			end else if (!rsp_valid) begin
				rsp_id <= ~rsp_id;
			end
		end
	end
endmodule : atoc_slave_model
`default_nettype wire

// file: bench/atoc_xbar_ctrl_test.sv
/*
 * Self-checking bench of the crossbar control block.
 * Assumes the slave model on the downstream side, ref_clk at 200 MHz.
 */
`include "atoc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module atoc_xbar_ctrl_test;
	import atoc_pkg::*;
	logic                 ref_clk, srst, dn_ready, rsp_valid, rsp_dir;
	logic [1:0][1:0]      cmd_valid, cmd_ack;
	logic [1:0][1:0][1:0] cmd_id;
	logic [1:0][1:0][31:0] cmd_addr;
	logic [1:0][1:0][7:0] cmd_len;
	logic [1:0][1:0][2:0] cmd_size, cmd_prot;
	logic [1:0]           wd_last, rsp_resp, up_id, up_resp;
	logic                 rsp_slot, rsp_last, dn_valid, dn_dir, dn_slot;
	logic [3:0]           rsp_id, dn_id;
	logic [31:0]          dn_addr, lite_awaddr, lite_araddr;
	logic [7:0]           dn_len;
	logic [2:0]           dn_size;
	logic                 rsp_ready, up_valid, up_dir, up_port, up_last;
	logic                 hold, slow, bad_id;      // Model controls
	logic [6:0]           up_q[$];                 // Seen replies
	logic [16:0]          dn_q[$];                 // Seen issued commands
	logic [31:0]          ad_q[$];                 // Their addresses
	int                   miscompares, check_count, cyc, rdy_cnt;
	// Directed corner table: address, length, size
	logic [31:0] ta[8] = '{32'h0000_1000, 32'h4000_0010, 32'h4001_0000,
		32'h4000_0020, 32'h4000_0030, 32'h3FFF_FF00, 32'hC000_0000,
		32'h0000_0100};
	logic [7:0]  tl[8] = '{8'h03, 8'h00, 8'h02, 8'h01, 8'h00, 8'h27, 8'h02,
		8'hFF};
	logic [2:0]  ts[8] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h2, 3'h1, 3'h0};

	atoc_xbar_ctrl i_atoc_xbar_ctrl (.ref_clk(ref_clk), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .cmd_size(cmd_size), .cmd_prot(cmd_prot),
		.wd_last(wd_last), .dn_ready(dn_ready), .rsp_valid(rsp_valid),
		.rsp_dir(rsp_dir), .rsp_slot(rsp_slot), .rsp_id(rsp_id),
		.rsp_resp(rsp_resp), .rsp_last(rsp_last), .cmd_ack(cmd_ack),
		.dn_valid(dn_valid), .dn_dir(dn_dir), .dn_slot(dn_slot),
		.dn_id(dn_id), .dn_addr(dn_addr), .dn_len(dn_len),
		.dn_size(dn_size), .lite_awaddr(lite_awaddr),
		.lite_araddr(lite_araddr), .rsp_ready(rsp_ready),
		.up_valid(up_valid), .up_dir(up_dir), .up_port(up_port),
		.up_id(up_id), .up_resp(up_resp), .up_last(up_last));

	atoc_slave_model i_atoc_slave_model (.ref_clk(ref_clk), .srst(srst),
		.dn_valid(dn_valid), .dn_dir(dn_dir), .dn_slot(dn_slot),
		.dn_id(dn_id), .dn_len(dn_len), .rsp_ready(rsp_ready),
		.hold(hold), .slow(slow), .bad_id(bad_id), .dn_ready(dn_ready),
		.rsp_valid(rsp_valid), .rsp_dir(rsp_dir), .rsp_slot(rsp_slot),
		.rsp_id(rsp_id), .rsp_resp(rsp_resp), .rsp_last(rsp_last));

	// Verdict and end of run
	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	// Flag compare
	task automatic check_bit(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check_bit

	// Reply compare; last ignored on forwarded writes
	task automatic check_up(input logic [6:0] e);
		logic [6:0] g;
		int         n = 0;
		while (up_q.size() == 0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		g = (up_q.size() > 0) ? up_q.pop_front() : ~e;
		if (!e[6] && e[2:1] != `ATOC_RESP_DECERR)
			g[0] = e[0];
		check_bit(g === e, "reply fields");
	endtask : check_up

	// Issued command compare
	task automatic check_dn(input logic [16:0] e, input logic [31:0] ea);
		int n = 0;
		while (dn_q.size() == 0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		if (dn_q.size() == 0)
			check_bit(1'b0, "command not issued");
		else
			check_bit({dn_q.pop_front(), ad_q.pop_front()} === {e, ea},
				"issued command");
	endtask : check_dn

	// Decoded slot, 2 for no match
	function automatic logic [1:0] slot_of(input logic [31:0] a);
		if ((a & `ATOC_S0_MASK) == `ATOC_S0_BASE)
			return 2'h0;
		if ((a & `ATOC_S1_MASK) == `ATOC_S1_BASE)
			return 2'h1;
		return 2'h2;
	endfunction : slot_of

	// Present one command until acknowledged
	task automatic issue(input logic d, input logic u, input logic [1:0] id,
		input logic [31:0] a, input logic [7:0] l, input logic [2:0] s);
		int n = 0;
		cmd_valid[d][u] <= 1'b1;
		cmd_id[d][u]    <= id;
		cmd_addr[d][u]  <= a;
		cmd_len[d][u]   <= l;
		cmd_size[d][u]  <= s;
		cmd_prot[d][u]  <= 3'($urandom);
		do begin
			@(posedge ref_clk);
			n++;
		end while (cmd_ack[d][u] !== 1'b1 && n < 400);
		cmd_valid[d][u] <= 1'b0;
		@(posedge ref_clk);
		check_bit(n < 400, "command never taken");
	endtask : issue

	// Full transaction, expected from the map
	task automatic do_txn(input logic d, input logic u, input logic [1:0] id,
		input logic [31:0] a, input logic [7:0] l, input logic [2:0] s);
		logic [1:0]  sl;
		logic        trap;
		logic [31:0] pa;
		logic [7:0]  pl;
		int          rem;
		int          nb;
		sl   = slot_of(a);
		trap = sl == 2'h2 ||
			(sl == 2'h1 && (l != 8'h00 || s > `ATOC_LITE_MAXSIZE));
		issue(d, u, id, a, l, s);
		if (trap && !d) begin
			wd_last[u] <= 1'b1;
			@(posedge ref_clk);
			wd_last[u] <= 1'b0;
		end
		pa  = a;
		rem = trap ? 0 : int'(l) + 1;
		while (rem > 0) begin
			pl  = (sl == 2'h0 && rem > 16) ? `ATOC_A3_MAXLEN : 8'(rem - 1);
			check_dn({d, sl[0], 1'b0, u, id, pl, s}, pa);
			pa  = pa + (32'h10 << s);
			rem = rem - int'(pl) - 1;
		end
		if (!trap && sl[0])
			check_bit(lite_awaddr === a && lite_araddr === a, "lite addr");
		nb = d ? int'(l) : 0;
		for (int i = 0; i <= nb; i++)
			check_up({d, u, id, trap ? `ATOC_RESP_DECERR : 2'h0, i == nb});
	endtask : do_txn

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Monitor and run ceiling
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (up_valid === 1'b1)
			up_q.push_back({up_dir, up_port, up_id, up_resp, up_last});
		if (dn_valid === 1'b1 && dn_ready === 1'b1) begin
			dn_q.push_back({dn_dir, dn_slot, dn_id, dn_len, dn_size});
			ad_q.push_back(dn_addr);
		end
		if (rsp_ready === 1'b1)
			rdy_cnt <= rdy_cnt + 1;
		if (cyc == 40000) begin
			miscompares++;
			$display("unexpected at %0t: run ceiling reached", $time);
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		int          r;
		int          n0;
		logic [31:0] a;
		logic [7:0]  l;
		srst        = 1'b1;
		{cmd_valid, cmd_id, wd_last, hold, slow, bad_id} = '0;
		{cmd_addr, cmd_len, cmd_size, cmd_prot} = '0;
		{miscompares, check_count, cyc, rdy_cnt} = '0;
		void'($urandom(32'h695B));
		repeat (10) @(posedge ref_clk);
		check_bit(dn_valid === 1'b0 && up_valid === 1'b0 &&
			cmd_ack === 4'h0 && rsp_ready === 1'b0, "outputs in reset");
		srst <= 1'b0;
		@(posedge ref_clk);
		// Corner table on every direction and upstream
		for (int k = 0; k < 8; k++)
			for (int j = 0; j < 4; j++)
				do_txn(j[1], j[0], 2'(k), ta[k], tl[k], ts[k]);
		// Thread held while it has a reply pending elsewhere
		hold <= 1'b1;
		issue(1'b1, 1'b0, 2'h1, 32'h0000_2000, 8'h00, 3'h2);
		fork
			issue(1'b1, 1'b0, 2'h1, 32'h4000_0040, 8'h00, 3'h2);
			begin
				repeat (30) @(posedge ref_clk);
				check_bit(dn_q.size() == 1, "thread moved early");
				hold <= 1'b0;
			end
		join
		check_dn({4'h8, 2'h1, 8'h00, 3'h2}, 32'h0000_2000);
		check_dn({4'hC, 2'h1, 8'h00, 3'h2}, 32'h4000_0040);
		check_up({4'h9, 2'h0, 1'b1});
		check_up({4'h9, 2'h0, 1'b1});
		// One slot, two sources outstanding together
		hold <= 1'b1;
		fork
			issue(1'b1, 1'b0, 2'h0, 32'h0000_3000, 8'h00, 3'h2);
			begin
				repeat (2) @(posedge ref_clk);
				issue(1'b1, 1'b1, 2'h0, 32'h0000_3100, 8'h00, 3'h2);
			end
		join
		repeat (4) @(posedge ref_clk);
		check_bit(dn_q.size() == 2, "slot took one source");
		hold <= 1'b0;
		check_dn({4'h8, 2'h0, 8'h00, 3'h2}, 32'h0000_3000);
		check_dn({4'h9, 2'h0, 8'h00, 3'h2}, 32'h0000_3100);
		check_up({4'h8, 2'h0, 1'b1});
		check_up({4'hC, 2'h0, 1'b1});
		// Random traffic over the whole map
		for (int i = 0; i < 40; i++) begin
			r = $urandom % 4;
			a = $urandom;
			if (r < 2)
				a[31:30] = 2'h0;
			else if (r == 2)
				a[31:16] = 16'h4000;
			else
				a[31:30] = 2'h2;
			l = (r == 2) ? 8'($urandom % 6 == 0) : 8'($urandom % 48);
			slow <= 1'($urandom);
			do_txn(1'($urandom), 1'($urandom), 2'($urandom), a, l,
				3'($urandom % ((r == 2) ? 4 : 8)));
		end
		// Reply with unknown prefix is never taken
		slow   <= 1'b0;
		bad_id <= 1'b1;
		n0 = rdy_cnt;
		repeat (40) @(posedge ref_clk);
		check_bit(rdy_cnt == n0 && up_q.size() == 0, "stray reply");
		bad_id <= 1'b0;
		srst   <= 1'b1;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		do_txn(1'b1, 1'b1, 2'h3, 32'h0000_0040, 8'h01, 3'h2);
		check_bit(up_q.size() == 0 && dn_q.size() == 0, "leftover traffic");
		give_verdict();
	end
endmodule : atoc_xbar_ctrl_test
`default_nettype wire
